// file: rtl/tmc_pkg.sv
// Constants shared by the 16-bit timer with input capture
package tmc_pkg;
    // ------------------------------------------------------------
    // Register offsets on the 8-bit CPU port
    // ------------------------------------------------------------
    localparam logic [3:0] OFS_CTRL_A = 4'h0;
    localparam logic [3:0] OFS_CTRL_B = 4'h1;
    localparam logic [3:0] OFS_CNT_LO = 4'h2;
    localparam logic [3:0] OFS_CNT_HI = 4'h3;
    localparam logic [3:0] OFS_CAP_LO = 4'h4;
    localparam logic [3:0] OFS_CAP_HI = 4'h5;
    localparam logic [3:0] OFS_CMPA_LO = 4'h6;
    localparam logic [3:0] OFS_CMPA_HI = 4'h7;
    localparam logic [3:0] OFS_FLAGS = 4'h8;
    localparam logic [3:0] OFS_MASK = 4'h9;
    localparam logic [3:0] OFS_CMP_CS = 4'ha;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int BIT_NF_EN = 7;      // Control B: noise filter enable
    localparam int BIT_EDGE_POL = 6;   // Control B: 1 = rising edge
    localparam int BIT_WGM_HI = 3;     // Control B: mode bits 3:2 at 4:3
    localparam int BIT_CAP_FLAG = 5;   // Flags / mask: capture
    localparam int BIT_OVF_FLAG = 0;   // Flags / mask: overflow
    localparam int BIT_TRIG_SEL = 2;   // Comparator ctrl: trigger select
    localparam int BIT_CMP_OUT = 5;    // Comparator ctrl: output, read only
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;
    // ------------------------------------------------------------
    // Clock select codes and prescaler masks
    // ------------------------------------------------------------
    localparam logic [2:0] CS_STOP = 3'h0;
    localparam logic [2:0] CS_DIV1 = 3'h1;
    localparam logic [2:0] CS_DIV8 = 3'h2;
    localparam logic [2:0] CS_DIV64 = 3'h3;
    localparam logic [2:0] CS_DIV256 = 3'h4;
    localparam logic [2:0] CS_DIV1024 = 3'h5;
    localparam logic [2:0] CS_EXT_FALL = 3'h6;
    localparam logic [2:0] CS_EXT_RISE = 3'h7;
    localparam logic [9:0] PS_MASK_8 = 10'h007;
    localparam logic [9:0] PS_MASK_64 = 10'h03f;
    localparam logic [9:0] PS_MASK_256 = 10'h0ff;
    localparam logic [9:0] PS_MASK_1024 = 10'h3ff;
    // ------------------------------------------------------------
    // Mode table, indexed by the 4-bit waveform mode field
    // ------------------------------------------------------------
    localparam logic [15:0] MODE_DUAL_MASK = 16'h0f0e;
    localparam logic [15:0] MODE_CAP_TOP_MASK = 16'h5500;
    localparam logic [15:0] MODE_CMPA_TOP_MASK = 16'h8a10;
    localparam logic [15:0] TOP_8BIT = 16'h00ff;
    localparam logic [15:0] TOP_9BIT = 16'h01ff;
    localparam logic [15:0] TOP_10BIT = 16'h03ff;
    localparam logic [15:0] CNT_MAX = 16'hffff;
    localparam logic [15:0] CNT_ONE = 16'h0001;
    // Noise filter sample count
    localparam int FILT_LEN = 4;
endpackage

// file: rtl/tmc_timer16_capture.sv
// 16-bit up/down timer core with shared high-byte register and capture
// ------------------------------------------------------------
// Operation
// [RQ1] 16-bit counter, steps by one, clears to zero
// [RQ2] Bottom at zero; maximum of sequence flagged
// [RQ3] 3-bit clock select; zero stops counting
// [RQ4] High byte via shared holding register
// [RQ5] CPU reads and writes counter anytime
// [RQ6] CPU counter write beats clear or count
// [RQ7] 4-bit mode field sets counting sequence
// [RQ8] Overflow flag set at mode's defined point
// [RQ9] Software may reuse holding byte, atomically
// [RQ10] Matching edge copies counter into capture
// [RQ11] Capture flag set with capture update
// [RQ12] Capture flag cleared by service or one
// [RQ13] Capture read low first via holding
// [RQ14] Capture writable only as top value
// [RQ15] Trigger select bit picks pin or comparator
// [RQ16] Both sources share synchronizer and detector
// [RQ17] Capture disabled in capture-top modes
// [RQ18] Filter output moves after four agreeing samples
// [RQ19] Filter enable bit, system clock, four cycles
// [RQ20] Each capture overwrites previous value
// [RQ21] Software-driven pin captures like external event
// [RQ22] Duty cycle: flip edge, then clear flag
// [RQ23] Write high first, read low first
// [RQ24] Top is fixed, compare A, or capture
// [RQ25] Polarity bit picks rising or falling edge
// ------------------------------------------------------------
module tmc_timer16_capture
    import tmc_pkg::*;
(
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst,
    // CPU register port
    input wire logic [3:0] i_addr,
    input wire logic i_wr_en,
    input wire logic i_rd_en,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_rdata,
    // Interrupt service acknowledges
    input wire logic i_capture_irq_ack,
    input wire logic i_overflow_irq_ack,
    // Asynchronous pins
    input wire logic i_capture_pin,
    input wire logic i_comparator_output,
    input wire logic i_external_clock_pin,
    // Interrupt requests and counter state
    output logic o_capture_irq,
    output logic o_overflow_irq,
    output logic o_at_bottom,
    output logic o_at_top,
    output logic o_at_max
);
    import tmc_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    localparam int SRC_PIN = 0;
    localparam int SRC_CMP = 1;
    localparam int SRC_EXT = 2;

    logic [7:0] ctrl_a_ff;       // Mode bits 1:0 in low bits
    logic [7:0] ctrl_b_ff;       // Filter, polarity, mode hi, clock sel
    logic [7:0] mask_ff;         // Interrupt enables
    logic trig_sel_ff;           // 1 = comparator drives capture
    logic [7:0] temp_ff;         // Shared high-byte holding register
    logic [15:0] count_ff;       // The counter
    logic [15:0] nxt_count;
    logic dir_down_ff;           // Dual-slope direction
    logic nxt_dir_down;
    logic [15:0] cap_ff;         // Capture register
    logic [15:0] cmpa_ff;        // Compare A, used as top
    logic cap_flag_ff;
    logic ovf_flag_ff;
    logic ovf_set;               // Overflow point reached this cycle
    logic [2:0] sync1_ff;        // First synchronizer stage
    logic [2:0] sync2_ff;        // Second synchronizer stage
    logic ext_prev_ff;
    logic [9:0] psc_ff;          // Free prescaler
    logic tick;                  // One-cycle timer step enable
    logic [FILT_LEN-1:0] samp_ff;
    logic filt_ff;               // Filtered trigger level
    logic filt_prev_ff;
    logic cap_src;
    logic cap_event;
    logic [3:0] wgm;
    logic [2:0] cs;
    logic dual;
    logic cap_top;
    logic [15:0] top_val;
    logic cnt_wr;
    logic [7:0] nxt_rdata;

    assign wgm = {ctrl_b_ff[BIT_WGM_HI+1:BIT_WGM_HI], ctrl_a_ff[1:0]};
    assign cs = ctrl_b_ff[2:0];
    assign cnt_wr = i_wr_en && (i_addr == OFS_CNT_LO);

    // ------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------
    // Top source and slope from the mode field
    always_comb begin
        dual = MODE_DUAL_MASK[wgm];                        // [RQ7]
        cap_top = MODE_CAP_TOP_MASK[wgm];
        top_val = CNT_MAX;
        if (cap_top) begin
            top_val = cap_ff;                              // [RQ24]
        end else if (MODE_CMPA_TOP_MASK[wgm]) begin
            top_val = cmpa_ff;                             // [RQ24]
        end else if (!wgm[3]) begin
            case (wgm[1:0])
                2'h1: top_val = TOP_8BIT;                  // [RQ24]
                2'h2: top_val = TOP_9BIT;
                2'h3: top_val = TOP_10BIT;
                default: top_val = CNT_MAX;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Pin synchronizers
    // ------------------------------------------------------------
    // Two stages per pin; only stage two is looked at
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            sync1_ff <= 3'h0;
            sync2_ff <= 3'h0;
        end else begin
            sync1_ff[SRC_PIN] <= i_capture_pin;            // [RQ21]
            sync1_ff[SRC_CMP] <= i_comparator_output;      // [RQ16]
            sync1_ff[SRC_EXT] <= i_external_clock_pin;
            sync2_ff <= sync1_ff;
        end
    end

    // ------------------------------------------------------------
    // Clock select
    // ------------------------------------------------------------
    // Prescaler runs only while a source is selected
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            psc_ff <= 10'h000;
            ext_prev_ff <= 1'b0;
        end else begin
            ext_prev_ff <= sync2_ff[SRC_EXT];
            if (cs == CS_STOP) begin
                psc_ff <= 10'h000;
            end else begin
                psc_ff <= psc_ff + 10'h001;
            end
        end
    end

    // Timer step enable per clock select code
    always_comb begin
        case (cs)
            CS_STOP: tick = 1'b0;                          // [RQ3]
            CS_DIV1: tick = 1'b1;
            CS_DIV8: tick = (psc_ff & PS_MASK_8) == PS_MASK_8;
            CS_DIV64: tick = (psc_ff & PS_MASK_64) == PS_MASK_64;
            CS_DIV256: tick = (psc_ff & PS_MASK_256) == PS_MASK_256;
            CS_DIV1024: tick = psc_ff == PS_MASK_1024;
            CS_EXT_FALL: tick = ext_prev_ff && !sync2_ff[SRC_EXT];
            CS_EXT_RISE: tick = !ext_prev_ff && sync2_ff[SRC_EXT];
            default: tick = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // Counter unit
    // ------------------------------------------------------------
    // Next count; a CPU write beats any step
    always_comb begin
        nxt_count = count_ff;
        nxt_dir_down = dir_down_ff;
        ovf_set = 1'b0;
        if (cnt_wr) begin
            nxt_count = {temp_ff, i_wdata};                // [RQ4] [RQ6]
        end else if (tick && !dual) begin
            if (count_ff == top_val) begin
                nxt_count = RST_WORD;                      // [RQ1]
                ovf_set = 1'b1;                            // [RQ8]
            end else begin
                nxt_count = count_ff + CNT_ONE;            // [RQ1]
            end
        end else if (tick && !dir_down_ff) begin
            // Turn at or above top; a top of zero steps the count below zero to 16'hffff
            if (count_ff >= top_val) begin
                nxt_dir_down = 1'b1;
                nxt_count = count_ff - CNT_ONE;
            end else begin
                nxt_count = count_ff + CNT_ONE;
            end
        end else if (tick) begin
            if (count_ff == RST_WORD) begin
                nxt_dir_down = 1'b0;
                nxt_count = CNT_ONE;
                ovf_set = 1'b1;                            // [RQ8]
            end else begin
                nxt_count = count_ff - CNT_ONE;            // [RQ1]
            end
        end
    end

    // Counter, direction and state outputs
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            count_ff <= RST_WORD;
            dir_down_ff <= 1'b0;
            o_at_bottom <= 1'b1;
            o_at_top <= 1'b0;
            o_at_max <= 1'b0;
        end else begin
            count_ff <= nxt_count;                         // [RQ5]
            dir_down_ff <= nxt_dir_down;
            o_at_bottom <= nxt_count == RST_WORD;          // [RQ2]
            o_at_top <= nxt_count == top_val;              // [RQ2]
            o_at_max <= nxt_count == CNT_MAX;
        end
    end

    // ------------------------------------------------------------
    // Capture trigger path
    // ------------------------------------------------------------
    assign cap_src = trig_sel_ff ? sync2_ff[SRC_CMP]
                                 : sync2_ff[SRC_PIN];      // [RQ15] [RQ16]

    // Filter: level moves only when all samples agree
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            samp_ff <= '0;
            filt_ff <= 1'b0;
            filt_prev_ff <= 1'b0;
        end else begin
            samp_ff <= {samp_ff[FILT_LEN-2:0], cap_src};
            filt_prev_ff <= filt_ff;
            if (!ctrl_b_ff[BIT_NF_EN]) begin
                filt_ff <= cap_src;
            end else if (&samp_ff) begin
                filt_ff <= 1'b1;                           // [RQ18] [RQ19]
            end else if (~|samp_ff) begin
                filt_ff <= 1'b0;                           // [RQ18]
            end
        end
    end

    // Edge detector; a source switch may look like an edge
    assign cap_event = !cap_top && (ctrl_b_ff[BIT_EDGE_POL]
        ? (filt_ff && !filt_prev_ff)
        : (!filt_ff && filt_prev_ff));                     // [RQ17] [RQ25]

    // ------------------------------------------------------------
    // Capture and compare registers
    // ------------------------------------------------------------
    // Capture overwrites; CPU write only in capture-top modes
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            cap_ff <= RST_WORD;
            cmpa_ff <= RST_WORD;
        end else begin
            if (cap_event) begin
                cap_ff <= count_ff;                        // [RQ10] [RQ20]
            end else if (cap_top && i_wr_en && i_addr == OFS_CAP_LO) begin
                cap_ff <= {temp_ff, i_wdata};              // [RQ14]
            end
            if (i_wr_en && i_addr == OFS_CMPA_LO) begin
                cmpa_ff <= {temp_ff, i_wdata};             // [RQ23]
            end
        end
    end

    // Holding register: loaded by high writes and counter or capture low reads
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            temp_ff <= RST_BYTE;
        end else if (i_wr_en && (i_addr == OFS_CNT_HI ||
                     i_addr == OFS_CAP_HI || i_addr == OFS_CMPA_HI)) begin
            temp_ff <= i_wdata;                            // [RQ4] [RQ23]
        end else if (i_rd_en && i_addr == OFS_CNT_LO) begin
            temp_ff <= count_ff[15:8];                     // [RQ4]
        end else if (i_rd_en && i_addr == OFS_CAP_LO) begin
            temp_ff <= cap_ff[15:8];                       // [RQ13]
        end
    end

    // ------------------------------------------------------------
    // Control registers and flags
    // ------------------------------------------------------------
    // Plain control bytes
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            ctrl_a_ff <= RST_BYTE;
            ctrl_b_ff <= RST_BYTE;
            mask_ff <= RST_BYTE;
            trig_sel_ff <= 1'b0;
        end else if (i_wr_en) begin
            if (i_addr == OFS_CTRL_A) begin
                ctrl_a_ff <= i_wdata;
            end
            if (i_addr == OFS_CTRL_B) begin
                ctrl_b_ff <= i_wdata;                      // [RQ3] [RQ19]
            end
            if (i_addr == OFS_MASK) begin
                mask_ff <= i_wdata;
            end
            if (i_addr == OFS_CMP_CS) begin
                trig_sel_ff <= i_wdata[BIT_TRIG_SEL];      // [RQ15]
            end
        end
    end

    // Flags: a set in the clearing cycle wins
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            cap_flag_ff <= 1'b0;
            ovf_flag_ff <= 1'b0;
        end else begin
            if (cap_event) begin
                cap_flag_ff <= 1'b1;                       // [RQ11]
            end else if (i_capture_irq_ack || (i_wr_en &&
                         i_addr == OFS_FLAGS && i_wdata[BIT_CAP_FLAG])) begin
                cap_flag_ff <= 1'b0;                       // [RQ12]
            end
            if (ovf_set) begin
                ovf_flag_ff <= 1'b1;                       // [RQ8]
            end else if (i_overflow_irq_ack || (i_wr_en &&
                         i_addr == OFS_FLAGS && i_wdata[BIT_OVF_FLAG])) begin
                ovf_flag_ff <= 1'b0;
            end
        end
    end

    // Interrupt requests, flag gated by its enable
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            o_capture_irq <= 1'b0;
            o_overflow_irq <= 1'b0;
        end else begin
            o_capture_irq <= cap_flag_ff && mask_ff[BIT_CAP_FLAG]; // [RQ11]
            o_overflow_irq <= ovf_flag_ff && mask_ff[BIT_OVF_FLAG];
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    // Read mux; unmapped offsets answer zero
    always_comb begin
        nxt_rdata = RST_BYTE;
        case (i_addr)
            OFS_CTRL_A: nxt_rdata = ctrl_a_ff;
            OFS_CTRL_B: nxt_rdata = ctrl_b_ff;
            OFS_CNT_LO: nxt_rdata = count_ff[7:0];         // [RQ5]
            OFS_CNT_HI: nxt_rdata = temp_ff;               // [RQ4]
            OFS_CAP_LO: nxt_rdata = cap_ff[7:0];
            OFS_CAP_HI: nxt_rdata = temp_ff;               // [RQ13]
            OFS_CMPA_LO: nxt_rdata = cmpa_ff[7:0];
            OFS_CMPA_HI: nxt_rdata = cmpa_ff[15:8];        // [RQ23]
            OFS_FLAGS: begin
                nxt_rdata[BIT_CAP_FLAG] = cap_flag_ff;
                nxt_rdata[BIT_OVF_FLAG] = ovf_flag_ff;
            end
            OFS_MASK: nxt_rdata = mask_ff;
            OFS_CMP_CS: begin
                nxt_rdata[BIT_TRIG_SEL] = trig_sel_ff;
                nxt_rdata[BIT_CMP_OUT] = sync2_ff[SRC_CMP];
            end
            default: nxt_rdata = RST_BYTE;
        endcase
    end

    // Registered read data, one cycle after the strobe
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            o_rdata <= RST_BYTE;
        end else if (i_rd_en) begin
            o_rdata <= nxt_rdata;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (i_rst);

    sequence s_cnt_low_read;
        i_rd_en && !i_wr_en && i_addr == OFS_CNT_LO;
    endsequence

    sequence s_cnt_low_write;
        i_wr_en && i_addr == OFS_CNT_LO;
    endsequence

    a_stop_holds: assert property (cs == CS_STOP && !cnt_wr // [RQ3]
        |=> $stable(count_ff)) else $error("count moved while stopped");
    a_write_wins: assert property (s_cnt_low_write // [RQ6]
        |=> count_ff == {$past(temp_ff), $past(i_wdata)})
        else $error("counter write lost");
    a_temp_on_read: assert property (s_cnt_low_read ##1 1'b1 // [RQ4]
        |-> temp_ff == $past(count_ff[15:8]))
        else $error("holding byte not loaded");
    a_bottom_state: assert property ( // [RQ2]
        o_at_bottom == (count_ff == RST_WORD))
        else $error("bottom indication wrong");
    a_capture_copy: assert property (cap_event // [RQ10]
        |=> cap_ff == $past(count_ff) && cap_flag_ff)
        else $error("capture not taken with flag");
    a_flag_ack: assert property (i_capture_irq_ack && !cap_event // [RQ12]
        |=> !cap_flag_ff) else $error("capture flag not cleared");
    a_capture_blocked: assert property (cap_top && !(i_wr_en // [RQ17]
        && i_addr == OFS_CAP_LO) |=> $stable(cap_ff) && !$rose(cap_flag_ff))
        else $error("capture in capture-top mode");
    a_filter_agree: assert property ($past(ctrl_b_ff[BIT_NF_EN]) && // [RQ18]
        filt_ff != $past(filt_ff) |-> $past(samp_ff) == {FILT_LEN{filt_ff}})
        else $error("filter moved without agreement");
    a_normal_step: assert property (tick && !cnt_wr && wgm == 4'h0 // [RQ1]
        && count_ff != CNT_MAX |=> count_ff == $past(count_ff) + CNT_ONE)
        else $error("count step wrong");
    a_ovf_single: assert property (tick && !cnt_wr && !dual // [RQ8]
        && count_ff == top_val |=> ovf_flag_ff && count_ff == RST_WORD)
        else $error("overflow at top missing");
endmodule

// file: verification/tmc_cpu_model.sv
// CPU-side model: byte and word accesses on the timer register port
module tmc_cpu_model
    import tmc_pkg::*;
(
    // Clock
    input wire logic i_mclk,
    // Register port towards the timer
    output logic [3:0] o_addr,
    output logic o_wr_en,
    output logic o_rd_en,
    output logic [7:0] o_wdata,
    input wire logic [7:0] i_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle bus at time zero
    initial begin
        o_addr = 4'hf;
        o_wr_en = 1'b0;
        o_rd_en = 1'b0;
        o_wdata = 8'h00;
    end
    // Byte write; released data shows the inverse, never the old value
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        o_addr <= a;
        o_wdata <= d;
        o_wr_en <= 1'b1;
        @(posedge i_mclk);
        o_wr_en <= 1'b0;
        o_wdata <= ~d;
    endtask
    // Byte read; data is taken once it has settled after the strobe
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge i_mclk);
        o_addr <= a;
        o_rd_en <= 1'b1;
        @(posedge i_mclk);
        o_rd_en <= 1'b0;
        @(posedge i_mclk);
        #1 d = i_rdata;
    endtask
    // Word write, high byte into holding first
    task automatic wr16(input logic [3:0] lo, input logic [15:0] v);
        wr(lo + 4'h1, v[15:8]);
        wr(lo, v[7:0]);
    endtask
    // Word read, low byte first so holding gets the high byte
    task automatic rd16(input logic [3:0] lo, output logic [15:0] v);
        rd(lo, v[7:0]);
        rd(lo + 4'h1, v[15:8]);
    endtask
endmodule

// file: verification/timer16_counter_input_capture_tb.sv
// Self-checking bench for the 16-bit timer with input capture
module timer16_counter_input_capture_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import tmc_pkg::*;
    logic i_mclk = 1'b0;
    logic i_rst = 1'b1;
    logic cap_ack = 1'b0;
    logic ovf_ack = 1'b0;
    logic pin = 1'b0;
    logic cmp = 1'b0;
    logic ext = 1'b0;
    logic [3:0] addr;
    logic wr_en;
    logic rd_en;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic cap_irq;
    logic ovf_irq;
    logic at_bottom;
    logic at_top;
    logic at_max;
    logic [31:0] seed = 32'h0000d0c0; // Fixed seed for repeatable runs
    logic [15:0] v;
    logic [15:0] r;
    logic [7:0] b;
    int error_cnt = 0;
    int checks = 0;
    always #5 i_mclk = ~i_mclk; // 100 MHz
    tmc_cpu_model tmc_cpu_model_inst (.i_mclk(i_mclk), .o_addr(addr),
        .o_wr_en(wr_en), .o_rd_en(rd_en), .o_wdata(wdata), .i_rdata(rdata));
    tmc_timer16_capture tmc_timer16_capture_inst (.i_mclk(i_mclk),
        .i_rst(i_rst), .i_addr(addr), .i_wr_en(wr_en), .i_rd_en(rd_en),
        .i_wdata(wdata), .o_rdata(rdata), .i_capture_irq_ack(cap_ack),
        .i_overflow_irq_ack(ovf_ack), .i_capture_pin(pin),
        .i_comparator_output(cmp), .i_external_clock_pin(ext),
        .o_capture_irq(cap_irq), .o_overflow_irq(ovf_irq),
        .o_at_bottom(at_bottom), .o_at_top(at_top), .o_at_max(at_max));
    // Xorshift source for counter values
    function automatic logic [15:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[15:0];
    endfunction
    // Expected control B byte from its fields
    function automatic logic [7:0] ctl_b(logic f, logic p, logic [1:0] w,
        logic [2:0] cs);
        return {f, p, 1'b0, w, cs};
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Level change on pin or comparator, then time for sync and filter
    task automatic drive(input int s, input logic l);
        @(posedge i_mclk);
        if (s == 1) cmp <= l;
        else pin <= l;
        repeat (12) @(posedge i_mclk);
    endtask
    task automatic flag(input int bitn, input logic exp);
        tmc_cpu_model_inst.rd(OFS_FLAGS, b);
        check(b[bitn], exp);
    endtask
    task automatic print_verdict();
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // Watchdog far beyond the expected run length
    initial begin
        #200000;
        error_cnt++;
        print_verdict();
    end
    initial begin
        repeat (6) @(posedge i_mclk);
        i_rst <= 1'b0;
        @(posedge i_mclk);
        check(at_bottom, 1'b1);
        // Word writes and reads while stopped, max value first
        for (int i = 0; i < 4; i++) begin
            v = (i == 0) ? CNT_MAX : rnd();
            tmc_cpu_model_inst.wr16(OFS_CNT_LO, v);
            tmc_cpu_model_inst.rd16(OFS_CNT_LO, r);
            check(r, v);
            check(at_max, v == CNT_MAX);
        end
        // Holding byte reused by a lone low write; compare A high is direct
        tmc_cpu_model_inst.wr(OFS_CMPA_LO, 8'h5a);
        tmc_cpu_model_inst.rd(OFS_CMPA_HI, b);
        check(b, v[15:8]);
        // Write while counting beats the tick; wrap sets overflow
        tmc_cpu_model_inst.wr(OFS_MASK, 8'h21);
        tmc_cpu_model_inst.wr(OFS_CTRL_B, ctl_b(0, 0, 2'h0, CS_DIV1));
        tmc_cpu_model_inst.wr16(OFS_CNT_LO, 16'hfffe);
        tmc_cpu_model_inst.wr(OFS_CTRL_B, ctl_b(0, 1, 2'h0, CS_STOP));
        tmc_cpu_model_inst.rd16(OFS_CNT_LO, r);
        check(r, 16'h0000);
        flag(BIT_OVF_FLAG, 1'b1);
        check(ovf_irq, 1'b1);
        tmc_cpu_model_inst.wr(OFS_FLAGS, 8'h01);
        flag(BIT_OVF_FLAG, 1'b0);
        repeat (20) @(posedge i_mclk);
        tmc_cpu_model_inst.rd16(OFS_CNT_LO, v);
        check(v, r);
        // Divide by eight: steps land 8, 16 and 24 cycles in
        tmc_cpu_model_inst.wr16(OFS_CNT_LO, 16'h0000);
        tmc_cpu_model_inst.wr(OFS_CTRL_B, ctl_b(0, 1, 2'h0, CS_DIV8));
        repeat (28) @(posedge i_mclk);
        tmc_cpu_model_inst.wr(OFS_CTRL_B, ctl_b(0, 1, 2'h0, CS_STOP));
        tmc_cpu_model_inst.rd16(OFS_CNT_LO, r);
        check(r, 16'h0003);
        // Pin clock: three rising, then three falling edges
        for (int e = 0; e < 2; e++) begin
            tmc_cpu_model_inst.wr16(OFS_CNT_LO, 16'h0000);
            tmc_cpu_model_inst.wr(OFS_CTRL_B,
                ctl_b(0, 1, 2'h0, e ? CS_EXT_FALL : CS_EXT_RISE));
            repeat (6) begin
                @(posedge i_mclk);
                ext <= ~ext;
                repeat (4) @(posedge i_mclk);
            end
            tmc_cpu_model_inst.rd16(OFS_CNT_LO, r);
            check(r, 16'h0003);
        end
        tmc_cpu_model_inst.wr(OFS_CTRL_B, ctl_b(0, 1, 2'h0, CS_STOP));
        // Fixed top of mode 1
        tmc_cpu_model_inst.wr(OFS_CTRL_A, 8'h01);
        tmc_cpu_model_inst.wr16(OFS_CNT_LO, TOP_8BIT);
        repeat (2) @(posedge i_mclk);
        check(at_top, 1'b1);
        tmc_cpu_model_inst.wr(OFS_CTRL_A, 8'h00);
        // Comparator then pin, rising edge polarity
        for (int s = 1; s >= 0; s--) begin
            tmc_cpu_model_inst.wr(OFS_CMP_CS, 8'(s << BIT_TRIG_SEL));
            tmc_cpu_model_inst.wr(OFS_FLAGS, 8'h20);
            v = rnd();
            tmc_cpu_model_inst.wr16(OFS_CNT_LO, v);
            drive(s, 1'b1);
            flag(BIT_CAP_FLAG, 1'b1);
            check(cap_irq, 1'b1);
            tmc_cpu_model_inst.rd16(OFS_CAP_LO, r);
            check(r, v);
            @(posedge i_mclk);
            cap_ack <= 1'b1;
            @(posedge i_mclk);
            cap_ack <= 1'b0;
            flag(BIT_CAP_FLAG, 1'b0);
            drive(s, 1'b0);
            flag(BIT_CAP_FLAG, 1'b0);
        end
        // Filter rejects a three-cycle glitch, passes a held level
        tmc_cpu_model_inst.wr(OFS_CTRL_B, ctl_b(1, 1, 2'h0, CS_STOP));
        @(posedge i_mclk);
        pin <= 1'b1;
        repeat (2) @(posedge i_mclk);
        drive(0, 1'b0);
        flag(BIT_CAP_FLAG, 1'b0);
        drive(0, 1'b1);
        flag(BIT_CAP_FLAG, 1'b1);
        // Capture-top mode 12: capture writable, events ignored
        tmc_cpu_model_inst.wr(OFS_FLAGS, 8'h20);
        tmc_cpu_model_inst.wr(OFS_CTRL_B, ctl_b(0, 1, 2'h3, CS_STOP));
        v = rnd();
        tmc_cpu_model_inst.wr16(OFS_CAP_LO, v);
        tmc_cpu_model_inst.rd16(OFS_CAP_LO, r);
        check(r, v);
        drive(0, 1'b0);
        drive(0, 1'b1);
        flag(BIT_CAP_FLAG, 1'b0);
        print_verdict();
    end
endmodule
